// >>> svcp_host_model.sv
// Serial bus host that issues word writes and word reads.
`timescale 1ns/100ps
module svcp_host_model
  import svcp_pkg::*;
(
  // Wire drive and sensed data level
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Data changes well after the clock fall and is read in the middle of the high phase.
  task automatic bit_io(input logic b, output logic r);
    #50 sda_out = b;
    #20 scl_out = 1'b1;
    #27.5 r = sda_in;
    #27.5 scl_out = 1'b0;
  endtask
  task automatic start;
    #50 sda_out = 1'b1;
    #20 scl_out = 1'b1;
    #27.5 sda_out = 1'b0;
    #27.5 scl_out = 1'b0;
  endtask
  task automatic stop;
    #50 sda_out = 1'b0;
    #20 scl_out = 1'b1;
    #27.5 sda_out = 1'b1;
    #27.5;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, ar);
  endtask
  task automatic write_word(input logic [6:0] ad, input logic [7:0] c, d0, d1, output logic [3:0] nk);
    logic [7:0] r;
    start;
    byte_io({ad, DIR_WRITE}, 1'b1, r, nk[3]);
    byte_io(c, 1'b1, r, nk[2]);
    byte_io(d0, 1'b1, r, nk[1]);
    byte_io(d1, 1'b1, r, nk[0]);
    stop;
  endtask
  task automatic read_word(input logic [7:0] c, output logic [7:0] r0, r1, output logic [2:0] nk);
    logic [7:0] r;
    logic x;
    start;
    byte_io({SLAVE_ADDR, DIR_WRITE}, 1'b1, r, nk[2]);
    byte_io(c, 1'b1, r, nk[1]);
    start;
    byte_io({SLAVE_ADDR, DIR_READ}, 1'b1, r, nk[0]);
    byte_io(8'hff, 1'b0, r0, x);
    byte_io(8'hff, 1'b1, r1, x);
    stop;
  endtask
endmodule

// >>> svcp_pkg.sv
// Shared constants and types of the bus-programmed divider code block.
package svcp_pkg;

  // Hardwired slave address and direction-bit values.
  localparam logic [6:0] SLAVE_ADDR = 7'h71;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Command encodings on the top three bits of the command byte.
  localparam logic [2:0] CMD_ON = 3'h0;
  localparam logic [2:0] CMD_SETUP = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_OFF = 3'h3;

  // Byte positions inside one transfer.
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD = 2'h1;
  localparam logic [1:0] BYTE_DATA0 = 2'h2;
  localparam logic [1:0] BYTE_DATA1 = 2'h3;

  // Divider code layout inside a data byte and its reset value.
  localparam int CODE_W = 5;
  localparam int CODE_LSB = 3;
  localparam int STATUS_BIT = 2;
  localparam logic [4:0] CODE_RESET = 5'h1f;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Power-good low pulse.
  localparam int PG_LOW_NS = 50000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PG_LOW_CYCLES = PG_LOW_NS / CLK_PERIOD_NS;
  localparam int PG_CNT_W = 16;

  // Bus interface states.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } svcp_state_t;

  // Pin levels sampled together.
  typedef struct packed {
    logic scl;
    logic sda;
    logic ge;
    logic sel;
  } svcp_pins_t;

  // Bus events found from the sampled pins.
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } svcp_bus_ev_t;

endpackage

// >>> svcp_top.sv
// Bus slave, command decoder, code registers and converter control of the divider block.
//
// Functional notes
// - Answer only slave address 1110001 (E2H with direction bit).
// - Direction bit low means host writes, high means host reads.
// - Decode only top three command bits; ignore undefined combinations.
// - 000 On, 011 Off, 001 Setup as writes; 010 readback as read.
// - Wrong address: no acknowledge, idle until next start condition.
// - Matching address: hold SDA low for the following clock period; a read address is acknowledged only while a readback command is pending.
// - Sample SDA on rising SCL, change driven SDA on falling SCL.
// - Acknowledge command and data of all writes; store data only on Setup.
// - Setup: first data byte to code register 0, second to register 1.
// - Top five bits of each data byte form the code; rest dropped.
// - After final data acknowledge, go idle and wait for a start.
// - Readback: repeated start, read address acknowledged, send register 0 then 1.
// - Send second byte only after host acknowledge of first; then idle.
// - Read byte: code on top, converter-off status next, two zeros.
// - Ignore On commands until a Setup has loaded the registers.
// - Bus-on rises after two On commands with no other own command between.
// - Bus-on falls after two Off commands with no other own command between.
// - On and Off never change either code register.
// - Setup cannot change codes while bus-on and global enable are high.
// - Active divider code is the register chosen by the select input.
// - Select high picks register 1, low picks register 0.
// - Converter-off is NAND of enable and bus-on; high holds controls low.
// - Reset: codes all ones, bus idle, converter-off forced high.
// - Power-good low pulse of 50 us on converter-off fall or select toggle.
`timescale 1ns/100ps
module svcp_top
  import svcp_pkg::*;
#(
  parameter int PG_CYCLES = PG_LOW_CYCLES
) (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Converter control pins
  input wire logic global_enable_input_in,
  input wire logic select_in,
  output logic [4:0] divider_code_bits_out,
  output logic converter_off_status_out,
  output logic bus_on_state_out,
  output logic conv_ctrl_out,
  output logic conv_ctrl_oe_out,
  output logic power_good_output_out,
  output logic power_good_output_oe_out
);

  if (PG_CYCLES < 1 || PG_CYCLES > 65535) begin : g_chk
    $error("PG_CYCLES must lie between 1 and 65535.");
  end

  // Builds a readback byte from a code and the converter-off status.
  function automatic logic [7:0] read_byte(input logic [4:0] code, input logic off);
    read_byte = {code, off, 2'b00};
  endfunction

  // Two-stage synchronisers plus one delay stage for edge finding.
  svcp_pins_t sync1_reg, sync2_reg, sync3_reg;
  svcp_bus_ev_t ev;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1_reg <= '{scl: 1'b1, sda: 1'b1, ge: 1'b0, sel: 1'b0};
      sync2_reg <= '{scl: 1'b1, sda: 1'b1, ge: 1'b0, sel: 1'b0};
      sync3_reg <= '{scl: 1'b1, sda: 1'b1, ge: 1'b0, sel: 1'b0};
    end else if (ce_in) begin
      sync1_reg <= '{scl: scl_in, sda: sda_in, ge: global_enable_input_in, sel: select_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  always_comb begin
    ev.start = sync3_reg.scl & sync2_reg.scl & sync3_reg.sda & ~sync2_reg.sda;
    ev.stop = sync3_reg.scl & sync2_reg.scl & ~sync3_reg.sda & sync2_reg.sda;
    ev.rise = ~sync3_reg.scl & sync2_reg.scl;
    ev.fall = sync3_reg.scl & ~sync2_reg.scl;
  end

  // Bus interface and command state.
  svcp_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] data0_reg, data0_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [1:0] byte_reg, byte_next;
  logic [2:0] cmd_reg, cmd_next;
  logic rd_pend_reg, rd_pend_next;
  logic rd_mode_reg, rd_mode_next;
  logic tx_second_reg, tx_second_next;
  logic host_ack_reg, host_ack_next;
  logic sda_oe_reg, sda_oe_next;
  logic [4:0] code0_reg, code0_next;
  logic [4:0] code1_reg, code1_next;
  logic setup_done_reg, setup_done_next;
  logic bus_on_reg, bus_on_next;
  logic on_pend_reg, on_pend_next;
  logic off_pend_reg, off_pend_next;
  logic off_reg;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    data0_next = data0_reg;
    bitcnt_next = bitcnt_reg;
    byte_next = byte_reg;
    cmd_next = cmd_reg;
    rd_pend_next = rd_pend_reg;
    rd_mode_next = rd_mode_reg;
    tx_second_next = tx_second_reg;
    host_ack_next = host_ack_reg;
    sda_oe_next = sda_oe_reg;
    code0_next = code0_reg;
    code1_next = code1_reg;
    setup_done_next = setup_done_reg;
    bus_on_next = bus_on_reg;
    on_pend_next = on_pend_reg;
    off_pend_next = off_pend_reg;
    if (ev.start) begin
      // A start abandons anything in progress; nothing is committed mid-way.
      state_next = ST_RX;
      bitcnt_next = 4'h0;
      byte_next = BYTE_ADDR;
      sda_oe_next = 1'b0;
    end else if (ev.stop) begin
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
      rd_pend_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_next = 1'b0;
        end
        ST_RX: begin
          if (ev.rise && bitcnt_reg != BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sync2_reg.sda};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (ev.fall && bitcnt_reg == BITS_PER_BYTE) begin
            state_next = ST_IDLE;
            unique case (byte_reg)
              BYTE_ADDR: begin
                if (shift_reg[7:1] == SLAVE_ADDR) begin
                  if (shift_reg[0] == DIR_WRITE) begin
                    state_next = ST_ACK;
                    rd_mode_next = 1'b0;
                    rd_pend_next = 1'b0;
                  end else if (rd_pend_reg) begin
                    state_next = ST_ACK;
                    rd_mode_next = 1'b1;
                    rd_pend_next = 1'b0;
                    on_pend_next = 1'b0;
                    off_pend_next = 1'b0;
                  end
                end
              end
              BYTE_CMD: begin
                cmd_next = shift_reg[7:5];
                if (shift_reg[7:5] == CMD_ON || shift_reg[7:5] == CMD_OFF
                    || shift_reg[7:5] == CMD_SETUP || shift_reg[7:5] == CMD_READ) begin
                  state_next = ST_ACK;
                end
              end
              BYTE_DATA0: begin
                data0_next = shift_reg;
                state_next = ST_ACK;
              end
              default: begin
                state_next = ST_ACK;
              end
            endcase
            sda_oe_next = (state_next == ST_ACK);
          end
        end
        ST_ACK: begin
          if (ev.fall) begin
            sda_oe_next = 1'b0;
            bitcnt_next = 4'h0;
            state_next = ST_RX;
            if (rd_mode_reg) begin
              tx_next = read_byte(code0_reg, off_reg);
              tx_second_next = 1'b0;
              sda_oe_next = ~tx_next[7];
              state_next = ST_TX;
            end else if (byte_reg == BYTE_CMD && cmd_reg == CMD_READ) begin
              rd_pend_next = 1'b1;
              state_next = ST_IDLE;
            end else if (byte_reg == BYTE_DATA1) begin
              state_next = ST_IDLE;
              unique case (cmd_reg)
                CMD_SETUP: begin
                  if (!(bus_on_reg && sync2_reg.ge)) begin
                    code0_next = data0_reg[CODE_LSB +: CODE_W];
                    code1_next = shift_reg[CODE_LSB +: CODE_W];
                    setup_done_next = 1'b1;
                  end
                  on_pend_next = 1'b0;
                  off_pend_next = 1'b0;
                end
                CMD_ON: begin
                  if (setup_done_reg) begin
                    off_pend_next = 1'b0;
                    on_pend_next = ~on_pend_reg;
                    if (on_pend_reg) begin
                      bus_on_next = 1'b1;
                    end
                  end
                end
                CMD_OFF: begin
                  on_pend_next = 1'b0;
                  off_pend_next = ~off_pend_reg;
                  if (off_pend_reg) begin
                    bus_on_next = 1'b0;
                  end
                end
                default: begin
                  on_pend_next = 1'b0;
                  off_pend_next = 1'b0;
                end
              endcase
            end else begin
              byte_next = byte_reg + 2'h1;
            end
          end
        end
        ST_TX: begin
          if (ev.rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (ev.fall) begin
            if (bitcnt_reg == BITS_PER_BYTE) begin
              sda_oe_next = 1'b0;
              state_next = ST_MACK;
            end else begin
              tx_next = {tx_reg[6:0], 1'b0};
              sda_oe_next = ~tx_reg[6];
            end
          end
        end
        default: begin
          if (ev.rise) begin
            host_ack_next = ~sync2_reg.sda;
          end else if (ev.fall) begin
            if (host_ack_reg && !tx_second_reg) begin
              tx_next = read_byte(code1_reg, off_reg);
              tx_second_next = 1'b1;
              bitcnt_next = 4'h0;
              sda_oe_next = ~tx_next[7];
              state_next = ST_TX;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      data0_reg <= 8'h00;
      bitcnt_reg <= 4'h0;
      byte_reg <= BYTE_ADDR;
      cmd_reg <= CMD_ON;
      rd_pend_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      tx_second_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      code0_reg <= CODE_RESET;
      code1_reg <= CODE_RESET;
      setup_done_reg <= 1'b0;
      bus_on_reg <= 1'b0;
      on_pend_reg <= 1'b0;
      off_pend_reg <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      data0_reg <= data0_next;
      bitcnt_reg <= bitcnt_next;
      byte_reg <= byte_next;
      cmd_reg <= cmd_next;
      rd_pend_reg <= rd_pend_next;
      rd_mode_reg <= rd_mode_next;
      tx_second_reg <= tx_second_next;
      host_ack_reg <= host_ack_next;
      sda_oe_reg <= sda_oe_next;
      code0_reg <= code0_next;
      code1_reg <= code1_next;
      setup_done_reg <= setup_done_next;
      bus_on_reg <= bus_on_next;
      on_pend_reg <= on_pend_next;
      off_pend_reg <= off_pend_next;
    end
  end

  // Converter control, power-good timer and active code.
  logic off_next;
  logic sel_prev_reg, sel_prev_next;
  logic [PG_CNT_W-1:0] pg_cnt_reg, pg_cnt_next;
  logic pg_low_reg, pg_low_next;
  logic [4:0] code_out_reg, code_out_next;
  logic trigger;

  always_comb begin
    off_next = ~(sync2_reg.ge & bus_on_reg);
    sel_prev_next = sync2_reg.sel;
    trigger = (off_reg & ~off_next) | (sel_prev_reg ^ sync2_reg.sel);
    if (trigger) begin
      pg_cnt_next = PG_CNT_W'(PG_CYCLES - 1);
    end else if (pg_cnt_reg != '0) begin
      pg_cnt_next = pg_cnt_reg - 1'b1;
    end else begin
      pg_cnt_next = pg_cnt_reg;
    end
    pg_low_next = off_next | trigger | (pg_cnt_reg > 1);
    code_out_next = sync2_reg.sel ? code1_reg : code0_reg;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      off_reg <= 1'b1;
      sel_prev_reg <= 1'b0;
      pg_cnt_reg <= '0;
      pg_low_reg <= 1'b1;
      code_out_reg <= CODE_RESET;
    end else if (ce_in) begin
      off_reg <= off_next;
      sel_prev_reg <= sel_prev_next;
      pg_cnt_reg <= pg_cnt_next;
      pg_low_reg <= pg_low_next;
      code_out_reg <= code_out_next;
    end
  end

  // Open-drain pins drive only low; the enables carry the behaviour.
  always_comb begin
    sda_out = 1'b0;
    conv_ctrl_out = 1'b0;
    power_good_output_out = 1'b0;
  end

  assign sda_oe_out = sda_oe_reg;
  assign divider_code_bits_out = code_out_reg;
  assign converter_off_status_out = off_reg;
  assign bus_on_state_out = bus_on_reg;
  assign conv_ctrl_oe_out = off_reg;
  assign power_good_output_oe_out = pg_low_reg;

endmodule

// >>> svcp_top_properties.sv
// Port checker of the divider block, bound to its top module.
`timescale 1ns/100ps
module svcp_top_properties
  import svcp_pkg::*;
#(
  parameter int PG_CYCLES = PG_LOW_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_oe_out,
  input wire logic global_enable_input_in,
  input wire logic select_in,
  input wire logic [4:0] divider_code_bits_out,
  input wire logic converter_off_status_out,
  input wire logic bus_on_state_out,
  input wire logic conv_ctrl_oe_out,
  input wire logic power_good_output_oe_out
);
  logic sel_reg, sel_next;
  logic [7:0] quiet_reg, quiet_next;
  logic [15:0] pg_reg, pg_next;
  // Counts cycles with SCL high and select steady, and pulse cycles since the last select change or converter-off fall.
  always_comb begin
    sel_next = select_in;
    quiet_next = (scl_in && select_in == sel_reg) ? quiet_reg + 8'h01 : 8'h00;
    pg_next = 16'h0000;
    if (power_good_output_oe_out && !converter_off_status_out && select_in == sel_reg) begin
      pg_next = pg_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk_in) begin
    sel_reg <= srst_in ? 1'b0 : sel_next;
    quiet_reg <= srst_in ? 8'h00 : quiet_next;
    pg_reg <= srst_in ? 16'h0000 : pg_next;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_en_low;
    !global_enable_input_in [*4];
  endsequence
  sequence s_off_fall;
    $fell(converter_off_status_out);
  endsequence
  AST_CONV_EQ_OFF: assert property (conv_ctrl_oe_out == converter_off_status_out)
    else $error("converter control differs from off status");
  AST_OFF_HOLDS_PG: assert property (converter_off_status_out [*2] |-> power_good_output_oe_out)
    else $error("power good released while off");
  AST_EN_LOW_OFF: assert property (s_en_low |=> converter_off_status_out)
    else $error("off status low while enable low");
  AST_BUSON_LOW_OFF: assert property (!bus_on_state_out |=> converter_off_status_out)
    else $error("off status low while bus-on low");
  AST_PG_PULSE_HOLD: assert property (s_off_fall |-> power_good_output_oe_out [*8])
    else $error("power good pulse too short");
  AST_PG_PULSE_LEN: assert property (pg_reg <= PG_CYCLES + 2)
    else $error("power good pulse too long");
  AST_PG_SEL: assert property (($changed(select_in) && !converter_off_status_out) |->
    ##[1:5] power_good_output_oe_out)
    else $error("no power good pulse on select toggle");
  AST_SDA_ON_LOW_SCL: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line changed while clock high");
  AST_BUSON_ON_LOW_SCL: assert property ($changed(bus_on_state_out) |-> !scl_in)
    else $error("bus-on changed outside a commit");
  AST_CODE_QUIET: assert property (quiet_reg >= 8'h06 |-> $stable(divider_code_bits_out))
    else $error("divider code changed without cause");
endmodule
bind svcp_top svcp_top_properties #(.PG_CYCLES(PG_CYCLES)) u_props (
  .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_oe_out(sda_oe_out),
  .global_enable_input_in(global_enable_input_in), .select_in(select_in),
  .divider_code_bits_out(divider_code_bits_out),
  .converter_off_status_out(converter_off_status_out),
  .bus_on_state_out(bus_on_state_out), .conv_ctrl_oe_out(conv_ctrl_oe_out),
  .power_good_output_oe_out(power_good_output_oe_out)
);

// >>> svcp_top_test.sv
// Self-checking bench of the divider block.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module svcp_top_test
  import svcp_pkg::*;
;
  localparam int PGC = 20;
  int miscompares = 0;
  int check_count = 0;
  logic clk = 1'b0, srst = 1'b1, en = 1'b0, sel = 1'b0, hscl, hsda, dsda, oe, off, bon, coe, pgoe;
  logic cc, pgd;
  logic [4:0] code;
  wire sda_w = hsda & (oe ? dsda : 1'b1);
  initial forever #5 clk = ~clk;
  svcp_host_model host (.scl_out(hscl), .sda_out(hsda), .sda_in(sda_w));
  svcp_top #(.PG_CYCLES(PGC)) DUT (.clk_in(clk), .srst_in(srst), .ce_in(1'b1), .scl_in(hscl),
    .sda_in(sda_w), .sda_out(dsda), .sda_oe_out(oe), .global_enable_input_in(en),
    .select_in(sel), .divider_code_bits_out(code), .converter_off_status_out(off),
    .bus_on_state_out(bon), .conv_ctrl_out(cc), .conv_ctrl_oe_out(coe),
    .power_good_output_out(pgd), .power_good_output_oe_out(pgoe));
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic clks(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] d0, d1);
    logic [3:0] nk;
    host.write_word(SLAVE_ADDR, {c, 5'h15}, d0, d1, nk);
    `CHK(nk, 4'h0)
    clks(8);
  endtask
  task automatic rb(input logic [7:0] e0, e1);
    logic [7:0] r0, r1;
    logic [2:0] nk;
    host.read_word({CMD_READ, 5'h00}, r0, r1, nk);
    `CHK(nk, 3'h0)
    `CHK({r0, r1}, {e0, e1})
    clks(4);
  endtask
  task automatic t_reset;
    `CHK({code, off, bon, coe, pgoe}, {CODE_RESET, 4'hb})
    `CHK({dsda, cc, pgd}, 3'h0)
  endtask
  task automatic t_rerun;
    cmd(CMD_ON, 8'h00, 8'h00);
    srst = 1'b1;
    clks(3);
    srst = 1'b0;
    clks(6);
    `CHK({code, off, bon, pgoe}, {CODE_RESET, 3'b101})
    cmd(CMD_ON, 8'h00, 8'h00);
    cmd(CMD_ON, 8'h00, 8'h00);
    `CHK(bon, 1'b0)
  endtask
  task automatic t_early_on_bad_addr;
    logic [3:0] nk;
    cmd(CMD_ON, 8'h12, 8'h34);
    cmd(CMD_ON, 8'h12, 8'h34);
    `CHK(bon, 1'b0)
    host.write_word(7'h70, {CMD_SETUP, 5'h00}, 8'h00, 8'h00, nk);
    `CHK(nk[3], 1'b1)
    clks(8);
    `CHK(code, CODE_RESET)
  endtask
  task automatic t_setup;
    cmd(CMD_SETUP, 8'h57, 8'h9b);
    `CHK(code, 5'h0a)
    sel = 1'b1;
    clks(8);
    `CHK(code, 5'h13)
    sel = 1'b0;
    clks(8);
    rb(8'h54, 8'h9c);
  endtask
  task automatic t_pair;
    logic [3:0] nk;
    cmd(CMD_ON, 8'h00, 8'h00);
    cmd(CMD_SETUP, 8'h57, 8'h9b);
    cmd(CMD_ON, 8'h00, 8'h00);
    `CHK(bon, 1'b0)
    host.write_word(7'h22, {CMD_OFF, 5'h00}, 8'h00, 8'h00, nk);
    cmd(CMD_ON, 8'hff, 8'hff);
    `CHK({bon, code}, {1'b1, 5'h0a})
  endtask
  task automatic t_enable;
    en = 1'b1;
    clks(8);
    `CHK({off, coe, pgoe}, 3'b001)
    clks(PGC + 5);
    `CHK(pgoe, 1'b0)
    cmd(CMD_SETUP, 8'h08, 8'h08);
    `CHK(code, 5'h0a)
    rb(8'h50, 8'h98);
    sel = 1'b1;
    clks(8);
    `CHK({pgoe, code}, {1'b1, 5'h13})
    sel = 1'b0;
    clks(PGC + 10);
  endtask
  task automatic t_off;
    cmd(CMD_OFF, 8'h00, 8'h00);
    rb(8'h50, 8'h98);
    cmd(CMD_OFF, 8'h00, 8'h00);
    `CHK(bon, 1'b1)
    cmd(CMD_OFF, 8'h00, 8'h00);
    `CHK({bon, off, pgoe, code}, {3'b011, 5'h0a})
    en = 1'b0;
  endtask
  task automatic t_abort;
    logic [7:0] r;
    logic a;
    host.start;
    host.byte_io({SLAVE_ADDR, DIR_WRITE}, 1'b1, r, a);
    host.byte_io({CMD_SETUP, 5'h00}, 1'b1, r, a);
    host.byte_io(8'h08, 1'b1, r, a);
    host.start;
    host.stop;
    clks(8);
    `CHK(code, 5'h0a)
    cmd(CMD_SETUP, 8'h08, 8'hf8);
    `CHK(code, 5'h01)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    clks(10);
    t_reset;
    t_early_on_bad_addr;
    t_setup;
    t_pair;
    t_enable;
    t_off;
    t_abort;
    t_rerun;
    final_report;
  end
  initial begin
    #500000;
    miscompares++;
    final_report;
  end
endmodule
